// ===== prbr_rx_top.sv
// robbed-bit aware receive path: highway capture, clock crossing, fifo and expander
`timescale 1ns/10ps
`include "prbr_cfg.svh"
module prbr_rx_top import prbr_pkg::*; #(
  parameter int FIFO_DEPTH = `PRBR_FIFO_DEPTH
) (
  input logic CORE_CLK,
  input logic RESET_N,
  input logic PCM_BCLK,
  input logic FRAME_SYNC_PULSE,
  input logic PCM_RX_DATA,
  input logic ROBBED_BIT_ENABLE_FLAG,
  input logic MU_LAW_SELECT,
  input logic LINEAR_CODE_SELECT,
  input logic [`PRBR_SLOT_W-1:0] RX_TIME_SLOT,
  output logic [15:0] OUT_SAMPLE,
  output logic OUT_ROBBED,
  output logic OUT_VALID,
  input logic OUT_READY,
  output logic RX_OVERRUN
);
  logic [`PRBR_WORD_W-1:0] link_word;
  logic link_tog;
  logic [2:0] tog_sync_q;
  logic ev;
  prbr_xfer_state_t xs_q, xs_d;
  logic [`PRBR_WORD_W-1:0] cap_q;
  logic ovr_q;
  logic f_in_ready, f_out_valid, f_pop;
  logic [`PRBR_WORD_W-1:0] f_out_data;
  prbr_code_t code;
  logic sub_en;
  logic [7:0] rx_byte;
  logic [15:0] mu_val, a_val, lin_val, sample_d;
  logic [15:0] sample_q;
  logic robbed_out_q, valid_q;

  // mu-law expansion; half selects the half-LSB value in place of the received LSB
  function automatic logic [15:0] prbr_mu_expand(input logic [7:0] code_in, input logic half);
    logic [7:0] c;
    logic [4:0] m2;
    logic [15:0] mag;
    c = code_in ^ `PRBR_MU_INV;
    m2 = half ? {c[3:1], 2'b01} : {c[3:0], 1'b0};
    mag = (({11'h000, m2} << 2) + `PRBR_MU_BIAS) << c[6:4];
    mag = mag - `PRBR_MU_BIAS;
    return c[7] ? 16'(-mag) : mag;
  endfunction : prbr_mu_expand

  // A-law expansion with the alternate bit inversion removed
  function automatic logic [15:0] prbr_a_expand(input logic [7:0] code_in);
    logic [7:0] c;
    logic [15:0] mag;
    c = code_in ^ `PRBR_A_XOR;
    mag = {8'h00, c[3:0], `PRBR_A_HALF};
    if (c[6:4] != 3'h0) mag = (mag + `PRBR_A_SEG) << 3'(c[6:4] - 3'h1);
    return c[7] ? mag : 16'(-mag);
  endfunction : prbr_a_expand

  // highway side runs on the bit clock
  prbr_link_rx u_link (
    .pcm_bclk(PCM_BCLK),
    .reset_n(RESET_N),
    .sync_pin(FRAME_SYNC_PULSE),
    .dr_pin(PCM_RX_DATA),
    .en_in(ROBBED_BIT_ENABLE_FLAG),
    .mu_in(MU_LAW_SELECT),
    .lin_in(LINEAR_CODE_SELECT),
    .slot_in(RX_TIME_SLOT),
    .word_q(link_word),
    .tog_q(link_tog)
  );

  // toggle crossing: the word is held a whole slot, far longer than the sync delay
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) tog_sync_q <= '0;
    else tog_sync_q <= {tog_sync_q[1:0], link_tog};
  end
  assign ev = tog_sync_q[2] ^ tog_sync_q[1];

  // hold a captured word until the fifo takes it; this is where back-pressure stalls
  always_comb begin
    xs_d = xs_q;
    case (xs_q)
      PRBR_XS_IDLE: begin
        if (ev) xs_d = PRBR_XS_HOLD;
      end
      PRBR_XS_HOLD: begin
        if (f_in_ready && !ev) xs_d = PRBR_XS_IDLE;
      end
      default: xs_d = PRBR_XS_IDLE;
    endcase
  end

  // capture register and overrun pulse when a new word lands on a held one
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      xs_q <= PRBR_XS_IDLE;
      cap_q <= '0;
      ovr_q <= 1'b0;
    end else begin
      xs_q <= xs_d;
      if (ev) cap_q <= link_word;
      ovr_q <= ev && (xs_q == PRBR_XS_HOLD) && !f_in_ready;
    end
  end

  prbr_fifo #(
    .W(`PRBR_WORD_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .in_valid(xs_q == PRBR_XS_HOLD),
    .in_ready(f_in_ready),
    .in_data(cap_q),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  // coding select and substitution gate
  assign code = LINEAR_CODE_SELECT ? PRBR_CODE_LIN
              : (MU_LAW_SELECT ? PRBR_CODE_MU : PRBR_CODE_ALAW);
  assign rx_byte = f_out_data[7:0];
  assign sub_en = f_out_data[`PRBR_ROBBED_BIT] && (code == PRBR_CODE_MU);
  assign mu_val = prbr_mu_expand(rx_byte, sub_en);
  assign a_val = prbr_a_expand(rx_byte);
  assign lin_val = f_out_data[15:0];

  // expander selection; linear bypasses expansion entirely
  always_comb begin
    case (code)
      PRBR_CODE_MU: sample_d = mu_val;
      PRBR_CODE_LIN: sample_d = lin_val;
      default: sample_d = a_val;
    endcase
  end

  // output stage is a single register slice; it refills in the cycle it drains
  assign f_pop = f_out_valid && (!valid_q || OUT_READY);
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      sample_q <= '0;
      robbed_out_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      if (f_pop) sample_q <= sample_d;
      if (f_pop) robbed_out_q <= sub_en;
      if (f_pop) valid_q <= 1'b1;
      else if (OUT_READY) valid_q <= 1'b0;
    end
  end

  // receive-only block: no transmit byte is ever formed or altered here
  assign OUT_SAMPLE = sample_q;
  assign OUT_ROBBED = robbed_out_q;
  assign OUT_VALID = valid_q;
  assign RX_OVERRUN = ovr_q;

  a_lsb_ignored: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (f_pop && sub_en) |=> sample_q == prbr_mu_expand($past(rx_byte) ^ 8'h01, 1'b1)
      && sample_q != prbr_mu_expand($past(rx_byte), 1'b0))
    else $error("robbed byte still depends on its received LSB");
  a_normal_full_byte: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (f_pop && !f_out_data[`PRBR_ROBBED_BIT] && code == PRBR_CODE_MU)
      |=> sample_q == prbr_mu_expand($past(rx_byte), 1'b0) && !robbed_out_q)
    else $error("normal frame byte not expanded on all eight bits");
  a_alaw_no_subst: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (f_pop && code == PRBR_CODE_ALAW) |=> sample_q == prbr_a_expand($past(rx_byte))
      && !robbed_out_q)
    else $error("A-law byte altered by robbed-bit handling");
  // a word on offer must not move under a stalled consumer
  a_out_follows_pop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (valid_q && !OUT_READY) |=> valid_q && $stable(sample_q) && $stable(robbed_out_q))
    else $error("output word changed before it was taken");
  a_pop_shows_word: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    f_pop |=> valid_q)
    else $error("popped word did not reach the output");
  a_lin_no_subst: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (f_pop && code == PRBR_CODE_LIN) |=> sample_q == $past(lin_val) && !robbed_out_q)
    else $error("linear word altered by robbed-bit handling");
  a_robbed_mu_only: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (f_pop && code != PRBR_CODE_MU) |=> !robbed_out_q)
    else $error("robbed flag shown outside mu-law");
  // overrun may only be reported when the held word really had nowhere to go
  a_overrun_when_full: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ovr_q |-> $past(xs_q) == PRBR_XS_HOLD && !$past(f_in_ready))
    else $error("overrun flagged with room in the fifo");
  a_hold_until_taken: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (xs_q == PRBR_XS_HOLD && !f_in_ready) |=> xs_q == PRBR_XS_HOLD)
    else $error("held word dropped while fifo full");
endmodule : prbr_rx_top

// ===== prbr_cfg.svh
// constants for the robbed-bit receive block: timing, field positions, expander figures
`ifndef PRBR_CFG_SVH
`define PRBR_CFG_SVH
`define PRBR_SLOT_W 7
`define PRBR_CNT_W 10
`define PRBR_BYTE_LAST 3'h7
`define PRBR_SYNC_ROBBED_LEN 2'h2
`define PRBR_SYNC_LEN_MAX 2'h3
`define PRBR_WORD_W 17
`define PRBR_ROBBED_BIT 16
`define PRBR_FIFO_DEPTH 4
`define PRBR_MU_INV 8'hFF
`define PRBR_MU_BIAS 16'h0084
`define PRBR_A_XOR 8'h55
`define PRBR_A_SEG 16'h0100
`define PRBR_A_HALF 4'h8
`endif

// ===== prbr_pkg.sv
// types shared by the robbed-bit receive block
package prbr_pkg;
  // crossing hand-off state, gray along idle -> hold -> idle
  typedef enum logic [1:0] {
    PRBR_XS_IDLE = 2'b00,
    PRBR_XS_HOLD = 2'b01
  } prbr_xfer_state_t;
  // receive coding selected by the operating functions setting
  typedef enum logic [1:0] {
    PRBR_CODE_ALAW = 2'b00,
    PRBR_CODE_MU = 2'b01,
    PRBR_CODE_LIN = 2'b11
  } prbr_code_t;
endpackage : prbr_pkg

// ===== prbr_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module prbr_fifo #(
  parameter int W = 17,
  parameter int D = 4
) (
  input logic clk,
  input logic rst_n,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wr_q, rd_q;
  logic [CW-1:0] cnt_q;
  logic push, pop;

  // pointer step that also wraps for depths that are not powers of two
  function automatic logic [PW-1:0] prbr_ptr_next(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : prbr_ptr_next

  assign in_ready = (cnt_q != CW'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage is written only, never reset; emptiness is tracked by the count
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= prbr_ptr_next(wr_q);
      if (pop) rd_q <= prbr_ptr_next(rd_q);
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end
endmodule : prbr_fifo

// ===== prbr_link_rx.sv
// highway-side receive logic on the bit clock: sync classification and slot capture
`timescale 1ns/10ps
`include "prbr_cfg.svh"
module prbr_link_rx import prbr_pkg::*; (
  input logic pcm_bclk,
  input logic reset_n,
  input logic sync_pin,
  input logic dr_pin,
  input logic en_in,
  input logic mu_in,
  input logic lin_in,
  input logic [`PRBR_SLOT_W-1:0] slot_in,
  output logic [`PRBR_WORD_W-1:0] word_q,
  output logic tog_q
);
  logic [1:0] rst_q;
  logic lrst_n;
  logic [`PRBR_SLOT_W+2:0] cfg1_q, cfg2_q;
  logic en_s, mu_s, lin_s;
  logic [`PRBR_SLOT_W-1:0] slot_s, tgt;
  logic sync_q, prev_two_q, robbed_q;
  logic [1:0] sync_len_q;
  logic [`PRBR_CNT_W-1:0] bit_cnt_q, idx;
  logic [15:0] sh_q, sh_d;
  logic sync_start, sync_end, cur_two, robbed_d, emit;

  // reset and quasi-static settings each cross through two flops
  always_ff @(negedge pcm_bclk) begin
    rst_q <= {rst_q[0], reset_n};
    cfg1_q <= {en_in, mu_in, lin_in, slot_in};
    cfg2_q <= cfg1_q;
  end
  assign lrst_n = rst_q[1];
  assign {en_s, mu_s, lin_s, slot_s} = cfg2_q;

  // pulse shape and slot position decode
  assign sync_start = sync_pin && !sync_q;
  assign sync_end = !sync_pin && sync_q;
  assign cur_two = (sync_len_q == `PRBR_SYNC_ROBBED_LEN);
  assign robbed_d = en_s && mu_s && !lin_s && cur_two && !prev_two_q;
  assign idx = sync_start ? '0 : bit_cnt_q;
  assign sh_d = {sh_q[14:0], dr_pin};
  assign tgt = lin_s ? `PRBR_SLOT_W'(slot_s + 1'b1) : slot_s;
  assign emit = (idx[2:0] == `PRBR_BYTE_LAST) && (idx[`PRBR_CNT_W-1:3] == tgt);

  // sync sampling on the falling edge; pulse length saturates so long pulses never match
  always_ff @(negedge pcm_bclk) begin
    if (!lrst_n) begin
      sync_q <= 1'b0;
      sync_len_q <= '0;
      prev_two_q <= 1'b0;
      robbed_q <= 1'b0;
    end else begin
      sync_q <= sync_pin;
      if (sync_start) sync_len_q <= 2'h1;
      else if (sync_pin && sync_len_q != `PRBR_SYNC_LEN_MAX) sync_len_q <= sync_len_q + 2'h1;
      if (sync_start) robbed_q <= 1'b0;
      else if (sync_end) robbed_q <= robbed_d;
      if (sync_end) prev_two_q <= cur_two;
    end
  end

  // bit position and byte capture; signaling bits ride along untouched
  always_ff @(negedge pcm_bclk) begin
    if (!lrst_n) begin
      bit_cnt_q <= '0;
      sh_q <= '0;
      word_q <= '0;
      tog_q <= 1'b0;
    end else begin
      bit_cnt_q <= `PRBR_CNT_W'(idx + 1'b1);
      sh_q <= sh_d;
      if (emit) word_q <= lin_s ? {1'b0, sh_d} : {robbed_q, 8'h00, sh_d[7:0]};
      if (emit) tog_q <= !tog_q;
    end
  end

  a_rb_pulse_shape: assert property (@(negedge pcm_bclk) disable iff (!lrst_n)
    $rose(robbed_q) |-> !sync_q && $past(sync_q) && $past(sync_q, 2) && !$past(sync_q, 3))
    else $error("robbed frame flagged without a two-cycle sync pulse");
  a_rb_prev_pulse: assert property (@(negedge pcm_bclk) disable iff (!lrst_n)
    $rose(robbed_q) |-> !$past(prev_two_q) && prev_two_q)
    else $error("robbed frame flagged after a two-cycle previous pulse");
  a_rb_enable_mode: assert property (@(negedge pcm_bclk) disable iff (!lrst_n)
    $rose(robbed_q) |-> en_s && mu_s && !lin_s)
    else $error("robbed frame flagged while disabled or not in mu-law");
  a_slot_zero_start: assert property (@(negedge pcm_bclk) disable iff (!lrst_n)
    (sync_q && !$past(sync_q)) |-> bit_cnt_q == `PRBR_CNT_W'(1) && !robbed_q)
    else $error("frame start did not restart slot 0");
  a_emit_byte_edge: assert property (@(negedge pcm_bclk) disable iff (!lrst_n)
    $changed(tog_q) |-> bit_cnt_q[2:0] == 3'h0)
    else $error("byte emitted off a slot boundary");
endmodule : prbr_link_rx

// ===== prbr_hwy_model.sv
// highway timing model: free bit clock, frame sync and serial receive data
`timescale 1ns/10ps
module prbr_hwy_model (
  output logic bclk,
  output logic sync_line,
  output logic dr
);
  // highway clocks run continuously; phase offset keeps it unrelated to the core clock
  initial begin
    bclk = 1'b0;
    sync_line = 1'b0;
    dr = 1'b0;
    #7;
    forever #16 bclk = ~bclk;
  end

  // one frame, msb first; slot s carries base+s; lines change after the rising edge
  task automatic frame(input int sync_len, input int nslots, input logic [7:0] base);
    logic [7:0] b;
    repeat (4) @(posedge bclk);
    for (int i = 0; i < nslots * 8; i++) begin
      @(posedge bclk);
      b = base + 8'(i / 8);
      sync_line <= (i < sync_len);
      dr <= b[7 - (i % 8)];
    end
    @(posedge bclk);
    sync_line <= 1'b0;
    dr <= ~dr; // released line shows no stale bit
  endtask : frame
endmodule : prbr_hwy_model

// ===== testbench.sv
// self-checking bench for the robbed-bit receive path
`timescale 1ns/10ps
`include "prbr_cfg.svh"
module testbench;
  logic core_clk, reset_n, bclk, sync_line, dr, en, mu, lin, rdy, valid, robbed, ovr;
  logic [`PRBR_SLOT_W-1:0] slot;
  logic [15:0] sample;
  int errors, checks, ovr_seen;

  prbr_rx_top #(.FIFO_DEPTH(4)) i_prbr_rx_top (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .PCM_BCLK(bclk), .FRAME_SYNC_PULSE(sync_line), .PCM_RX_DATA(dr),
    .ROBBED_BIT_ENABLE_FLAG(en),
    .MU_LAW_SELECT(mu), .LINEAR_CODE_SELECT(lin), .RX_TIME_SLOT(slot), .OUT_SAMPLE(sample),
    .OUT_ROBBED(robbed), .OUT_VALID(valid), .OUT_READY(rdy), .RX_OVERRUN(ovr));
  prbr_hwy_model i_prbr_hwy_model (.bclk(bclk), .sync_line(sync_line), .dr(dr));

  // core clock, 20 ns
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // overrun is a one-cycle pulse, so latch it
  always @(posedge core_clk) begin
    if (ovr === 1'b1) ovr_seen <= 1;
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1

  // mu-law expansion; robbed frames use half a step in place of the lsb
  function automatic logic [15:0] mu_exp(input logic [7:0] b, input logic rb);
    logic [7:0] u;
    int t;
    u = ~b;
    t = rb ? 8 * (u[3:0] & 4'hE) + 32'h4 : 8 * u[3:0];
    t = ((t + 32'h84) << u[6:4]) - 32'h84;
    return u[7] ? 16'(-t) : 16'(t);
  endfunction : mu_exp

  // wait for a word with a bounded count, judge it, then accept it
  task automatic get_word(input logic [15:0] es, input logic er);
    int n;
    n = 0;
    @(negedge core_clk);
    while (valid !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    cmp1(valid, 1'b1);
    cmp16(sample, es);
    cmp1(robbed, er);
    rdy = 1'b1;
    @(negedge core_clk);
    rdy = 1'b0;
  endtask : get_word

  task automatic fr(input int len, input logic [7:0] base, input logic [15:0] es,
                    input logic er);
    i_prbr_hwy_model.frame(len, 4, base);
    get_word(es, er);
  endtask : fr

  // sync lengths 1,2,2,3,2: only a two after a non-two is robbed
  task automatic t_robbed();
    int lens[5] = '{1, 2, 2, 3, 2};
    logic rb[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] b;
    for (int k = 0; k < 5; k++) begin
      b = 8'h31 + 8'(k);
      fr(lens[k], b, mu_exp(b + 8'h02, rb[k]), rb[k]);
    end
  endtask : t_robbed

  // first and last slot of the frame, counted from the sync pulse
  task automatic t_slots();
    for (int s = 0; s < 4; s += 3) begin
      slot = 7'(s);
      fr(1, 8'h50, mu_exp(8'h50 + 8'(s), 1'b0), 1'b0);
      fr(2, 8'h50, mu_exp(8'h50 + 8'(s), 1'b1), 1'b1);
    end
    slot = 7'h02;
  endtask : t_slots

  task automatic t_disable();
    en = 1'b0;
    fr(1, 8'h31, mu_exp(8'h33, 1'b0), 1'b0);
    fr(2, 8'h31, mu_exp(8'h33, 1'b0), 1'b0);
    en = 1'b1;
  endtask : t_disable

  task automatic t_alaw();
    mu = 1'b0;
    fr(1, 8'hD3, 16'h0008, 1'b0);
    fr(2, 8'hD3, 16'h0008, 1'b0);
    mu = 1'b1;
  endtask : t_alaw

  // linear spans slots 2 and 3, high byte first
  task automatic t_linear();
    lin = 1'b1;
    fr(1, 8'h10, 16'h1213, 1'b0);
    fr(2, 8'h10, 16'h1213, 1'b0);
    lin = 1'b0;
  endtask : t_linear

  // consumer stalls while frames keep coming, then drains everything
  // six words fit (output, four fifo words, hold); the seventh overwrites the held one
  task automatic t_overrun();
    int n;
    int got;
    en = 1'b0;
    repeat (7) i_prbr_hwy_model.frame(1, 4, 8'h40);
    get_word(mu_exp(8'h42, 1'b0), 1'b0);
    n = 0;
    got = 0;
    while (n < 100) begin
      @(negedge core_clk);
      if (valid === 1'b1) begin
        cmp16(sample, mu_exp(8'h42, 1'b0));
        got++;
        rdy = 1'b1;
        @(negedge core_clk);
        rdy = 1'b0;
        n = 0;
      end else n++;
    end
    cmp16(16'(got), 16'h0005);
    cmp1(ovr_seen != 0, 1'b1);
    cmp1(valid, 1'b0);
    en = 1'b1;
  endtask : t_overrun

  // watchdog: 22 frames of 1.2 us expected
  initial begin
    #200000;
    errors++;
    conclude();
  end

  initial begin
    errors = 0;
    checks = 0;
    ovr_seen = 0;
    reset_n = 1'b0;
    en = 1'b1;
    mu = 1'b1;
    lin = 1'b0;
    slot = 7'h02;
    rdy = 1'b0;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    t_robbed();
    t_slots();
    t_disable();
    t_alaw();
    t_linear();
    t_overrun();
    conclude();
  end
endmodule : testbench
